// ==== csb_pkg.sv ====
/*
  Shared constants and types for the charge-short and cell-balance control.
  Assumes a 50 MHz device clock and registers written over a plain
  address/data write port.
*/
package csb_pkg;

  // ----------------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------------
  localparam int          CLOCK_MHZ         = 50;
  localparam int          DELAY_STEP_US     = 60;
  localparam int          DELAY_STEP_CYCLES = DELAY_STEP_US * CLOCK_MHZ;
  localparam int          HOUR_SECONDS      = 3600;
  localparam longint      HOUR_CYCLES       = longint'(HOUR_SECONDS)
                                              * longint'(CLOCK_MHZ)
                                              * 64'd1000000;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADDR_SHORT_CFG    = 8'h09;
  localparam logic [7:0]  ADDR_BAL_CFG      = 8'h0A;
  localparam logic [7:0]  SHORT_CFG_RESET   = 8'h00;
  localparam logic [7:0]  BAL_CFG_RESET     = 8'h00;
  localparam int          SHORT_DELAY_MSB   = 7;
  localparam int          SHORT_DELAY_LSB   = 4;
  localparam int          SHORT_THR_MSB     = 3;
  localparam int          SHORT_THR_LSB     = 0;
  localparam int          BAL_MODE_MSB      = 7;
  localparam int          BAL_MODE_LSB      = 6;
  localparam int          BAL_TMO_MSB       = 5;
  localparam int          BAL_TMO_LSB       = 4;
  localparam int          BAL_VOLT_MSB      = 3;
  localparam int          BAL_VOLT_LSB      = 0;

  // ----------------------------------------------------------------------
  // threshold scales, magnitudes in mV
  // ----------------------------------------------------------------------
  localparam logic [8:0]  SHORT_BASE_LO_MV  = 9'h00A;
  localparam logic [8:0]  SHORT_STEP_LO_MV  = 9'h005;
  localparam logic [8:0]  SHORT_BASE_HI_MV  = 9'h032;
  localparam logic [8:0]  SHORT_STEP_HI_MV  = 9'h019;
  localparam logic [11:0] BAL_TOP_MV        = 12'hF3C;
  localparam logic [11:0] BAL_STEP_MV       = 12'h064;
  localparam logic [3:0]  DELAY_CODE_RSVD   = 4'h0;
  localparam logic [3:0]  DELAY_CODE_MIN    = 4'h1;

  typedef enum logic [1:0] {
    BAL_OFF           = 2'b00,
    BAL_ALWAYS        = 2'b01,
    BAL_CHARGER       = 2'b10,
    BAL_CHARGER_TIMED = 2'b11
  } csb_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ACTIVE  = 2'b01,
    ST_EXPIRED = 2'b10
  } csb_state_type;

  // threshold magnitude; the sensed voltage is negative of this
  function automatic logic [8:0] short_thresh_mv(input logic [3:0] code,
                                                 input logic       range);
    logic [8:0] c;
    c = {5'h00, code};
    short_thresh_mv = range ? 9'(SHORT_BASE_HI_MV + c * SHORT_STEP_HI_MV)
                            : 9'(SHORT_BASE_LO_MV + c * SHORT_STEP_LO_MV);
  endfunction

  // qualification time in steps; reserved code acts as the shortest one
  function automatic logic [4:0] delay_steps(input logic [3:0] code);
    logic [3:0] eff;
    eff = (code == DELAY_CODE_RSVD) ? DELAY_CODE_MIN : code;
    delay_steps = 5'({1'b0, eff} + 5'h01);
  endfunction

endpackage

// ==== csb_balance_timer.sv ====
/*
  Balancing session timer: an hour prescaler and an hour counter.
  Assumes run is high only while current is diverted; clear restarts it.
*/
`timescale 1ns/1ps
module csb_balance_timer
  import csb_pkg::*;
#(
  parameter longint HOUR_CYCLES_P = HOUR_CYCLES
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [3:0] hourLimit,
  output logic            expired
);

  logic [39:0] tickCount_q;
  logic [3:0]  hourCount_q;
  logic        expired_q;
  wire         hourWrap = (tickCount_q == 40'(HOUR_CYCLES_P - 1));
  wire  [3:0]  hourNext = 4'(hourCount_q + 4'h1);

  always_ff @(posedge clock)
  begin
    if (rst || (ce && clear))
    begin
      tickCount_q <= 40'h0;
      hourCount_q <= 4'h0;
      expired_q   <= 1'b0;
    end
    else if (ce && run && !expired_q)
    begin
      tickCount_q <= hourWrap ? 40'h0 : 40'(tickCount_q + 40'h1);
      if (hourWrap)
      begin
        hourCount_q <= hourNext;
        expired_q   <= (hourNext >= hourLimit);
      end
    end
  end

  assign expired = expired_q;

endmodule

// ==== csb_ctrl.sv ====
/*
  Charge short-circuit qualification and automatic cell balancing control.
  Assumes synchronous comparator inputs from the analog front end and a
  simple register write port with registered read data.
*/
// Operation
// [R01] delay code in bits 7:4; 0001 is 120 us, +60 us per code, to 960 us
// [R02] qualification delay may double while balancing current flows
// [R03] threshold code bits 3:0, range 0: -10 mV, -5 mV steps, to -85 mV
// [R04] range 1 scales threshold fivefold: -50 mV to -425 mV in -25 mV steps
// [R05] mode bits 7:6; 00 disables balancing and is the default
// [R06] mode 01 balances always, starts at threshold, ends on timer expiry
// [R07] mode 01 restarts only after all cells fell below then one re-reached
// [R08] mode 10 balances only with charger present, stops on removal, no timer
// [R09] mode 11 needs charger, stops on removal or expiry; expiry needs replug
// [R10] timer starts when current is diverted, not at charger detection
// [R11] host keeps protection delays short while balancing is enabled; the bench runs its mode 01, 10 and 11 tests at delay code F, the longest
// [R12] timeout bits 5:4 give 1, 2, 4 or 8 hours, regardless of charger
// [R13] start threshold bits 3:0: 3.9 V falling 0.1 V per code to 2.4 V
// [R14] short declared when sense stays beyond threshold for delay; fet off
// [R15] reserved delay code 0000 acts as the shortest valid delay
`timescale 1ns/1ps
module csb_ctrl
  import csb_pkg::*;
#(
  parameter int     NUM_CELLS     = 8,
  parameter int     STEP_CYCLES   = DELAY_STEP_CYCLES,
  parameter longint HOUR_CYCLES_P = HOUR_CYCLES
)
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regWrEn,
  output logic      [7:0]           regRdData,
  input  wire logic                 currentSenseRange,
  input  wire logic                 senseBeyondThresh,
  input  wire logic [NUM_CELLS-1:0] cellAtThresh,
  input  wire logic                 chargerPresent,
  output logic      [8:0]           shortThreshMv,
  output logic      [11:0]          balanceThreshMv,
  output logic      [NUM_CELLS-1:0] bleedEnable,
  output logic                      balancing,
  output logic                      chargeShortCircuit,
  output logic                      chargeFetOn
);

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [7:0]  chargeShortConfig_q;
  logic [7:0]  balanceConfig_q;
  logic [7:0]  regRdData_q;
  wire         wrShort = ce && regWrEn && (regAddr == ADDR_SHORT_CFG);
  wire         wrBal   = ce && regWrEn && (regAddr == ADDR_BAL_CFG);
  wire  [7:0]  rdMux   = (regAddr == ADDR_SHORT_CFG) ? chargeShortConfig_q :
                         (regAddr == ADDR_BAL_CFG)   ? balanceConfig_q :
                                                       8'h00;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chargeShortConfig_q <= SHORT_CFG_RESET;
      balanceConfig_q     <= BAL_CFG_RESET;
      regRdData_q         <= 8'h00;
    end
    else if (ce)
    begin
      if (wrShort)
        chargeShortConfig_q <= regWrData;
      if (wrBal)
        balanceConfig_q <= regWrData;
      regRdData_q <= rdMux;
    end
  end

  // ----------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------
  wire [3:0]    chargeShortDelayCode =
                  chargeShortConfig_q[SHORT_DELAY_MSB:SHORT_DELAY_LSB];
  wire [3:0]    chargeShortThresholdCode =
                  chargeShortConfig_q[SHORT_THR_MSB:SHORT_THR_LSB];
  wire [1:0]    modeBits   = balanceConfig_q[BAL_MODE_MSB:BAL_MODE_LSB];
  csb_mode_type balanceMode;
  assign balanceMode = csb_mode_type'(modeBits); // R05
  wire [1:0]    balanceTimeoutCode = balanceConfig_q[BAL_TMO_MSB:BAL_TMO_LSB];
  wire [3:0]    balanceStartVoltageCode =
                  balanceConfig_q[BAL_VOLT_MSB:BAL_VOLT_LSB];
  wire [3:0]    hourLimit = 4'(4'h1 << balanceTimeoutCode); // R12
  wire [8:0]    shortThreshD = short_thresh_mv(chargeShortThresholdCode,
                                               currentSenseRange); // R03 R04
  wire [11:0]   balThreshD = 12'(BAL_TOP_MV - {8'h00, balanceStartVoltageCode}
                                 * BAL_STEP_MV); // R13

  // ----------------------------------------------------------------------
  // cell balancing state machine
  // ----------------------------------------------------------------------
  csb_state_type          state_q;
  csb_state_type          state_d;
  logic [NUM_CELLS-1:0]   bleed_q;
  logic                   balancing_q;
  logic                   timerExpired;
  wire anyHigh    = |cellAtThresh;
  wire needsChg   = (balanceMode == BAL_CHARGER) ||
                    (balanceMode == BAL_CHARGER_TIMED);
  wire timed      = (balanceMode == BAL_ALWAYS) ||
                    (balanceMode == BAL_CHARGER_TIMED);
  wire enabledNow = (balanceMode != BAL_OFF) && (!needsChg || chargerPresent);
  wire startBal   = (state_q == ST_IDLE) && enabledNow && anyHigh;
  wire diverting  = (state_q == ST_ACTIVE) && (|bleed_q);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (startBal)
          state_d = ST_ACTIVE; // R06
      ST_ACTIVE:
        if (!enabledNow)
          state_d = ST_IDLE; // R08 R09
        else if (timed && timerExpired)
          state_d = ST_EXPIRED; // R06 R12
      ST_EXPIRED:
        if (balanceMode == BAL_OFF || balanceMode == BAL_CHARGER)
          state_d = ST_IDLE;
        else if (balanceMode == BAL_ALWAYS && !anyHigh)
          state_d = ST_IDLE; // R07
        else if (balanceMode == BAL_CHARGER_TIMED && !chargerPresent)
          state_d = ST_IDLE; // R09
      default:
        state_d = ST_IDLE;
    endcase
  end

  wire [NUM_CELLS-1:0] bleedD = (state_d == ST_ACTIVE) ? cellAtThresh
                                                       : '0;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q     <= ST_IDLE;
      bleed_q     <= '0;
      balancing_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q     <= state_d;
      bleed_q     <= bleedD;
      balancing_q <= (state_d == ST_ACTIVE);
    end
  end

  // timer runs only while current is diverted, paused in ST_ACTIVE without bleeding, held clear outside ST_ACTIVE
  csb_balance_timer #(
    .HOUR_CYCLES_P (HOUR_CYCLES_P)
  ) u_timer (
    .clock     (clock),
    .rst       (rst),
    .ce        (ce),
    .clear     (state_q != ST_ACTIVE), // R10
    .run       (diverting), // R10
    .hourLimit (hourLimit),
    .expired   (timerExpired)
  );

  // ----------------------------------------------------------------------
  // charge short-circuit qualification
  // ----------------------------------------------------------------------
  // doubling is a choice: bleed current disturbs the sense path
  logic [17:0] qualCount_q;
  logic        short_q;
  logic        fetOn_q;
  wire  [17:0] baseLimit = 18'({13'h0, delay_steps(chargeShortDelayCode)}
                               * 18'(STEP_CYCLES)); // R01 R15
  wire  [17:0] qualLimit = diverting ? 18'(baseLimit << 1) : baseLimit; // R02
  wire         qualDone  = senseBeyondThresh &&
                           (18'(qualCount_q + 18'h1) >= qualLimit);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      qualCount_q <= 18'h0;
      short_q     <= 1'b0;
      fetOn_q     <= 1'b1;
    end
    else if (ce)
    begin
      // any break in the excursion restarts the qualification
      qualCount_q <= (senseBeyondThresh && !qualDone)
                       ? 18'(qualCount_q + 18'h1) : 18'h0; // R14
      // set wins over the clear that a config write gives
      short_q     <= qualDone || (short_q && !wrShort); // R14
      fetOn_q     <= !(qualDone || (short_q && !wrShort)); // R14
    end
  end

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  logic [8:0]  shortThreshMv_q;
  logic [11:0] balanceThreshMv_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shortThreshMv_q   <= SHORT_BASE_LO_MV;
      balanceThreshMv_q <= BAL_TOP_MV;
    end
    else if (ce)
    begin
      shortThreshMv_q   <= shortThreshD;
      balanceThreshMv_q <= balThreshD;
    end
  end

  assign regRdData          = regRdData_q;
  assign shortThreshMv      = shortThreshMv_q;
  assign balanceThreshMv    = balanceThreshMv_q;
  assign bleedEnable        = bleed_q;
  assign balancing          = balancing_q;
  assign chargeShortCircuit = short_q;
  assign chargeFetOn        = fetOn_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_excursion_done;
    ce && qualDone;
  endsequence

  chk_short_trip_fet: assert property ( // R14
    s_excursion_done |=> (short_q && !fetOn_q))
    else $error("short not declared after qualification");
  chk_short_needs_sense: assert property ( // R14
    (ce && !short_q) ##1 short_q |-> $past(senseBeyondThresh))
    else $error("short declared without sense excursion");
  chk_delay_decode: assert property ( // R01
    chargeShortDelayCode != DELAY_CODE_RSVD && !diverting |->
      baseLimit == 18'(({14'h0, chargeShortDelayCode} + 18'h1)
                       * 18'(STEP_CYCLES)))
    else $error("delay decode wrong");
  chk_delay_reserved: assert property ( // R15
    chargeShortDelayCode == DELAY_CODE_RSVD |->
      baseLimit == 18'(18'h2 * 18'(STEP_CYCLES)))
    else $error("reserved delay code not shortest");
  chk_delay_double: assert property ( // R02
    diverting |-> qualLimit == 18'(baseLimit << 1))
    else $error("delay not doubled while diverting");
  chk_thresh_range: assert property ( // R03 R04
    ce |=> shortThreshMv_q == 9'($past(currentSenseRange)
      ? SHORT_BASE_HI_MV + $past(chargeShortThresholdCode) * SHORT_STEP_HI_MV
      : SHORT_BASE_LO_MV + $past(chargeShortThresholdCode) * SHORT_STEP_LO_MV))
    else $error("threshold output not registered");
  chk_thresh_scale: assert property ( // R04
    currentSenseRange |-> shortThreshD ==
      9'(short_thresh_mv(chargeShortThresholdCode, 1'b0) * 9'h005))
    else $error("high range not fivefold");
  chk_bal_volt: assert property ( // R13
    balanceStartVoltageCode == 4'hF |-> balThreshD == 12'h960)
    else $error("lowest start threshold wrong");
  chk_mode_off: assert property ( // R05
    balanceMode == BAL_OFF && ce |=> state_q != ST_ACTIVE)
    else $error("balancing while disabled");
  chk_charger_drop: assert property ( // R08 R09
    needsChg && !chargerPresent && ce |=> bleed_q == '0)
    else $error("bleeding without charger");
  chk_expired_hold: assert property ( // R07
    state_q == ST_EXPIRED && balanceMode == BAL_ALWAYS && anyHigh && ce
      |=> state_q == ST_EXPIRED)
    else $error("restart before cells fell below threshold");
  chk_timeout_end: assert property ( // R06 R12
    state_q == ST_ACTIVE && timed && timerExpired && enabledNow && ce
      |=> state_q == ST_EXPIRED ##1 bleed_q == '0)
    else $error("timer expiry did not end balancing");
  chk_timer_start: assert property ( // R10
    state_q != ST_ACTIVE && ce |=> !timerExpired)
    else $error("timer not cleared outside session");

endmodule

// ==== csb_afe_model.sv ====
/*
  Front-end model: sense and cell comparators against the thresholds
  that the control block publishes.
  Assumes the bench drives the analog levels as magnitudes in mV.
*/
`timescale 1ns/1ps
module csb_afe_model
  import csb_pkg::*;
#(
  parameter int NUM_CELLS = 8
)
(
  input  wire logic [8:0]           shortThreshMv,
  input  wire logic [11:0]          balanceThreshMv,
  input  wire logic [8:0]           senseMv,
  input  wire logic [11:0]          cellMv [NUM_CELLS],
  output logic                      senseBeyondThresh,
  output logic      [NUM_CELLS-1:0] cellAtThresh
);
  // sense is negative: a larger magnitude lies beyond the threshold
  assign senseBeyondThresh = (senseMv >= shortThreshMv);

  always_comb
  begin
    for (int i = 0; i < NUM_CELLS; i++)
    begin
      cellAtThresh[i] = (cellMv[i] >= balanceThreshMv);
    end
  end
endmodule

// ==== csb_ctrl_tb.sv ====
/*
  Self-checking bench for the charge-short and cell-balance control.
  Assumes short time bases: 4 cycles per delay step, 16 cycles per hour.
*/
`timescale 1ns/1ps
module csb_ctrl_tb;
  import csb_pkg::*;

  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic        clock, rst, ce, regWrEn, currentSenseRange, chargerPresent;
  logic [7:0]  regAddr, regWrData, regRdData, cellAtThresh, bleedEnable;
  logic        senseBeyondThresh, balancing, chargeShortCircuit, chargeFetOn;
  logic [8:0]  shortThreshMv, senseMv;
  logic [11:0] balanceThreshMv;
  logic [11:0] cellMv [8];
  int          err_count, checks_done;

  typedef struct {
    logic [7:0] c9; logic rng; logic [7:0] ca;
    logic [8:0] expS; logic [11:0] expB;
  } csb_row_type;
  csb_row_type rows [4] = '{
    '{8'h10, 1'b0, 8'h00, 9'h00A, 12'hF3C},
    '{8'h1F, 1'b0, 8'h0F, 9'h055, 12'h960},
    '{8'h10, 1'b1, 8'h05, 9'h032, 12'hD48},
    '{8'h1F, 1'b1, 8'h0A, 9'h1A9, 12'hB54}};

  csb_ctrl #(.NUM_CELLS(8), .STEP_CYCLES(4), .HOUR_CYCLES_P(16)) i_csb_ctrl (
    .clock(clock), .rst(rst), .ce(ce), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
    .currentSenseRange(currentSenseRange),
    .senseBeyondThresh(senseBeyondThresh), .cellAtThresh(cellAtThresh),
    .chargerPresent(chargerPresent), .shortThreshMv(shortThreshMv),
    .balanceThreshMv(balanceThreshMv), .bleedEnable(bleedEnable),
    .balancing(balancing), .chargeShortCircuit(chargeShortCircuit),
    .chargeFetOn(chargeFetOn));

  csb_afe_model #(.NUM_CELLS(8)) i_csb_afe_model (
    .shortThreshMv(shortThreshMv), .balanceThreshMv(balanceThreshMv),
    .senseMv(senseMv), .cellMv(cellMv),
    .senseBeyondThresh(senseBeyondThresh), .cellAtThresh(cellAtThresh));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_val({11'h000, got}, {11'h000, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    // an idle edge keeps the strobes of two writes apart
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    tick(1);
    check_val({4'h0, regRdData}, {4'h0, exp});
  endtask

  // high level is above every start threshold, low level below all
  task automatic cells(input logic [7:0] m);
    for (int i = 0; i < 8; i++)
    begin
      cellMv[i] = m[i] ? 12'hFA0 : 12'h3E8;
    end
  endtask

  // a short dropout first proves that the count restarts
  task automatic short_test(input logic [3:0] code, input int len);
    wr(8'h09, {code, 4'h0});
    tick(2);
    check_bit(chargeShortCircuit, 1'b0);
    check_bit(chargeFetOn, 1'b1);
    senseMv = 9'h014;
    tick(len - 2);
    senseMv = 9'h000;
    tick(1);
    senseMv = 9'h014;
    tick(len - 1);
    check_bit(chargeShortCircuit, 1'b0);
    tick(2);
    check_bit(chargeShortCircuit, 1'b1);
    check_bit(chargeFetOn, 1'b0);
    senseMv = 9'h000;
    $display("short test code %h done", code);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end

  initial
  begin
    err_count = 0; checks_done = 0; rst = 1'b1; ce = 1'b1;
    regWrEn = 1'b0; regAddr = 8'h00; regWrData = 8'h00;
    currentSenseRange = 1'b0; chargerPresent = 1'b0; senseMv = 9'h000;
    cells(8'h00);
    tick(20);
    rst = 1'b0;
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h00);
    wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'h00);
    check_val({3'h0, shortThreshMv}, 12'h00A);
    check_val(balanceThreshMv, 12'hF3C);
    check_bit(chargeFetOn, 1'b1);
    $display("reset test done");
    foreach (rows[i])
    begin
      currentSenseRange = rows[i].rng;
      wr(8'h09, rows[i].c9);
      wr(8'h0A, rows[i].ca);
      tick(2);
      check_val({3'h0, shortThreshMv}, {3'h0, rows[i].expS});
      check_val(balanceThreshMv, rows[i].expB);
      rd(8'h09, rows[i].c9);
      rd(8'h0A, rows[i].ca);
    end
    currentSenseRange = 1'b0;
    $display("table test done");
    short_test(4'h1, 8);
    short_test(4'h0, 8);
    short_test(4'hF, 64);
    // mode 01, one hour; protection delay is left at code F, the longest
    wr(8'h0A, 8'h40);
    cells(8'h05);
    tick(2);
    check_bit(balancing, 1'b1);
    check_val({4'h0, bleedEnable}, 12'h005);
    tick(10);
    check_val({4'h0, bleedEnable}, 12'h005);
    tick(10);
    check_val({4'h0, bleedEnable}, 12'h000);
    tick(5);
    check_bit(balancing, 1'b0);
    cells(8'h00);
    tick(2);
    cells(8'h80);
    tick(2);
    check_val({4'h0, bleedEnable}, 12'h080);
    $display("mode 01 test done");
    wr(8'h0A, 8'h80);
    cells(8'h01);
    tick(3);
    check_bit(balancing, 1'b0);
    chargerPresent = 1'b1;
    tick(2);
    check_val({4'h0, bleedEnable}, 12'h001);
    tick(40);
    check_val({4'h0, bleedEnable}, 12'h001);
    chargerPresent = 1'b0;
    tick(2);
    check_bit(balancing, 1'b0);
    $display("mode 10 test done");
    wr(8'h0A, 8'hD0);
    chargerPresent = 1'b1;
    tick(2);
    check_val({4'h0, bleedEnable}, 12'h001);
    tick(26);
    check_val({4'h0, bleedEnable}, 12'h001);
    tick(10);
    check_val({4'h0, bleedEnable}, 12'h000);
    chargerPresent = 1'b0;
    tick(2);
    chargerPresent = 1'b1;
    tick(3);
    check_val({4'h0, bleedEnable}, 12'h001);
    wr(8'h0A, 8'h00);
    tick(2);
    check_bit(balancing, 1'b0);
    $display("mode 11 test done");
    wr(8'h0A, 8'h70);
    tick(2);
    check_bit(balancing, 1'b1);
    short_test(4'h1, 16);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    check_val({4'h0, bleedEnable}, 12'h000);
    check_bit(chargeShortCircuit, 1'b0);
    rd(8'h0A, 8'h00);
    $display("mid-run reset test done");
    // a low enable must freeze the qualification count
    senseMv = 9'h014;
    ce = 1'b0;
    tick(20);
    check_bit(chargeShortCircuit, 1'b0);
    ce = 1'b1;
    tick(7);
    check_bit(chargeShortCircuit, 1'b0);
    tick(1);
    check_bit(chargeShortCircuit, 1'b1);
    check_bit(chargeFetOn, 1'b0);
    senseMv = 9'h000;
    $display("clock enable test done");
    end_sim();
  end
endmodule
